// File: capbuf_port.sv
/*
 * capture buffer and output port of an 8-bit sampling converter:
 * fifo capture with selectable size or bypass, empty and full flags,
 * auto-stop, source-synchronous output with selectable strobe edge,
 * sample strobe and clock multiplier select, configured over apb.
 * assumes pclk is the internal sample clock base; wen_in, ren_in and
 * rclk_in come from the receiving device asynchronously; adc_sample is
 * on pclk; the tristate wires are resolved outside from the *_oe_n pins.
 */
// Notes on behaviour
// RULE_01 - multiplier select 00 bypass x1, 01 x2, 10 x4, 11 x8
// RULE_02 - sample rate is input clock times multiplier; bypass disables the pll
// RULE_03 - size select 00 bypass, 01 256, 10 512, 11 1024 bytes
// RULE_04 - separate read and write pointers, first byte in is first out
// RULE_05 - reading only after the buffer was filled to its size
// RULE_06 - fully read data cannot be read again; partial reads allowed
// RULE_07 - write enable rising resets both pointers and restarts writing
// RULE_08 - write enable wins over read enable while both are high
// RULE_09 - writing past full wraps over old data unless auto-stop halts it
// RULE_10 - empty flag rises on full read or reset, falls on a write
// RULE_11 - on empty the outputs rest at the idle level of the edge select
// RULE_12 - full flag rises at size, falls when reading and not full
// RULE_13 - bypass sends samples straight out, ignores controls, flags low
// RULE_14 - buffered bytes come out per read clock rise while read enabled
// RULE_15 - without valid data, outputs rest low if edge one, high if zero
// RULE_16 - data change with the strobe edge chosen by the edge select
// RULE_17 - strobe toggles always in bypass, only on valid data otherwise
// RULE_18 - output enable low floats data and strobe except in test mode
// RULE_19 - sample strobe marks each sample on the sample clock
// RULE_20 - output port is 8 bits straight binary
// RULE_21 - reset clears pointers, full low, empty high; held 4 sample clocks
// RULE_22 - one byte stored per sample clock while write enable is high
// RULE_23 - reader raises read enable on its clock, not during writing
// RULE_24 - one byte read per read clock rise while read enable is high
// RULE_25 - pointers are ten bits and wrap at the configured size
// RULE_26 - read clock is synchronised so flags change on sample clock edges
`timescale 1ns/1ps
`include "capbuf_regs.svh"
module capbuf_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] adc_sample,
    input wire logic wen_in,
    input wire logic ren_in,
    input wire logic rclk_in,
    output logic [7:0] out_data,
    output logic out_data_oe_n,
    output logic data_strobe_out,
    output logic data_strobe_oe_n,
    output logic sample_strobe_out,
    output logic empty_flag,
    output logic full_flag,
    output logic pll_enable
);
    localparam capbuf_pkg::state_t RESET_STATE = '{
        cfg: `CFG_RST,
        empty: 1'b1,
        phase: capbuf_pkg::PH_IDLE,
        default: '0
    };

    capbuf_pkg::state_t st;
    capbuf_pkg::state_t next_st;

    logic clk_mult_sel_lo;
    logic clk_mult_sel_hi;
    logic buf_size_sel_lo;
    logic buf_size_sel_hi;
    logic auto_stop_write;
    logic edge_sel;
    logic edge_eff;
    logic out_enable;
    logic test_mode;
    logic bypass;
    logic [4:0] div_len;
    logic [4:0] half_pt;
    logic tick;
    logic [10:0] size_bytes;
    logic [9:0] ptr_mask;
    logic wen_rise;
    logic rclk_rise;
    logic rclk_fall;
    logic read_now;
    logic mem_we;
    logic [7:0] mem_rdata;
    logic apb_wr;
    logic apb_setup;
    logic cfg_hit;
    logic stat_hit;

    // config fields
    assign clk_mult_sel_lo = st.cfg[`CFG_MULT_LO];
    assign clk_mult_sel_hi = st.cfg[`CFG_MULT_HI];
    assign buf_size_sel_lo = st.cfg[`CFG_SIZE_LO];
    assign buf_size_sel_hi = st.cfg[`CFG_SIZE_HI];
    assign auto_stop_write = st.cfg[`CFG_ASW];
    assign edge_sel = st.cfg[`CFG_EDGE];
    assign out_enable = st.cfg[`CFG_OE];
    assign test_mode = st.cfg[`CFG_TEST];
    // in test mode the auto-stop bit selects the edge instead
    assign edge_eff = test_mode ? auto_stop_write : edge_sel;

    // sample period shrinks with the multiplier; pll off at x1
    assign div_len = `SAMPLE_DIV_BASE >> {clk_mult_sel_hi, clk_mult_sel_lo}; // RULE_01 RULE_02
    assign half_pt = div_len >> 1;
    assign tick = (st.div_cnt == 5'h00);
    assign pll_enable = clk_mult_sel_hi | clk_mult_sel_lo; // RULE_02

    // buffer size and pointer wrap mask
    always_comb
    begin
        case ({buf_size_sel_hi, buf_size_sel_lo}) // RULE_03
            2'h1: size_bytes = `SIZE_256;
            2'h2: size_bytes = `SIZE_512;
            2'h3: size_bytes = `SIZE_1024;
            default: size_bytes = 11'h000;
        endcase
    end
    assign bypass = (size_bytes == 11'h000);
    assign ptr_mask = 10'(size_bytes - 11'h001); // RULE_25

    // edges of the synchronised pins
    assign wen_rise = st.wen_s & ~st.wen_d;
    assign rclk_rise = st.rclk_s & ~st.rclk_d;
    assign rclk_fall = ~st.rclk_s & st.rclk_d;
    // read only when filled, not writing, and data left
    assign read_now = !bypass && !test_mode && !st.wen_s && st.ren_s && rclk_rise
        && st.filled && (st.level != 11'h000); // RULE_05 RULE_06 RULE_08 RULE_24
    assign mem_we = !bypass && st.wen_s && !wen_rise && tick
        && !(auto_stop_write && st.level == size_bytes); // RULE_09 RULE_22

    // apb decode, zero wait states
    assign apb_wr = psel & penable & pwrite;
    assign apb_setup = psel & ~penable;
    assign cfg_hit = (paddr == `CFG_OFFSET);
    assign stat_hit = (paddr == `STATUS_OFFSET);
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~(cfg_hit | stat_hit);

    // next state
    always_comb
    begin
        next_st = st;
        // two-flop synchronisers, third stage for edge detection
        next_st.wen_m = wen_in;
        next_st.wen_s = st.wen_m;
        next_st.wen_d = st.wen_s;
        next_st.ren_m = ren_in;
        next_st.ren_s = st.ren_m;
        next_st.rclk_m = rclk_in; // RULE_26
        next_st.rclk_s = st.rclk_m;
        next_st.rclk_d = st.rclk_s;
        next_st.rd_pend = read_now;
        next_st.smp_strobe = tick; // RULE_19
        next_st.div_cnt = tick ? 5'(div_len - 5'h01) : 5'(st.div_cnt - 5'h01);

        // register access
        if (apb_wr && cfg_hit)
        begin
            next_st.cfg = pwdata[7:0];
        end
        if (apb_setup)
        begin
            next_st.prdata = 32'h0000_0000;
            if (cfg_hit)
            begin
                next_st.prdata[7:0] = st.cfg;
            end
            else if (stat_hit)
            begin
                next_st.prdata[`STAT_EMPTY] = st.empty;
                next_st.prdata[`STAT_FULL] = st.full;
                next_st.prdata[`STAT_PHASE_LSB +: 2] = st.phase;
                next_st.prdata[`STAT_LEVEL_LSB +: 11] = st.level;
                next_st.prdata[`STAT_WPTR_LSB +: 10] = st.wr_ptr;
            end
        end

        // buffer control
        if (bypass)
        begin
            next_st.empty = 1'b0; // RULE_13
            next_st.full = 1'b0;
            next_st.phase = capbuf_pkg::PH_IDLE;
        end
        else if (st.wen_s)
        begin
            next_st.phase = capbuf_pkg::PH_WRITE;
            if (wen_rise)
            begin
                // restart capture, even over a read in progress
                next_st.wr_ptr = 10'h000; // RULE_07
                next_st.rd_ptr = 10'h000;
                next_st.level = 11'h000;
                next_st.filled = 1'b0;
                next_st.empty = 1'b1;
                next_st.full = 1'b0;
            end
            else if (mem_we)
            begin
                next_st.wr_ptr = (st.wr_ptr + 10'h001) & ptr_mask; // RULE_04 RULE_25
                next_st.empty = 1'b0; // RULE_10
                if (st.level == size_bytes)
                begin
                    // wrap: oldest byte is overwritten
                    next_st.rd_ptr = (st.rd_ptr + 10'h001) & ptr_mask; // RULE_09
                end
                else
                begin
                    next_st.level = 11'(st.level + 11'h001);
                    if (11'(st.level + 11'h001) == size_bytes)
                    begin
                        next_st.full = 1'b1; // RULE_12
                        next_st.filled = 1'b1; // RULE_05
                    end
                end
            end
        end
        else
        begin
            next_st.phase = st.ren_s ? capbuf_pkg::PH_READ : capbuf_pkg::PH_IDLE;
            if (st.ren_s && st.level != size_bytes)
            begin
                next_st.full = 1'b0; // RULE_12
            end
            if (read_now)
            begin
                next_st.rd_ptr = (st.rd_ptr + 10'h001) & ptr_mask; // RULE_04 RULE_24
                next_st.level = 11'(st.level - 11'h001);
                if (st.level == 11'h001)
                begin
                    next_st.empty = 1'b1; // RULE_06 RULE_10
                end
                if (st.level == size_bytes)
                begin
                    next_st.full = 1'b0;
                end
            end
        end

        // output port
        if (test_mode)
        begin
            // training pattern, one byte per read clock
            if (rclk_rise)
            begin
                next_st.test_hi = ~st.test_hi;
                next_st.out_data = st.test_hi ? 8'hFF : 8'h00;
                next_st.strobe = edge_eff;
            end
            else if (rclk_fall)
            begin
                next_st.strobe = ~edge_eff;
            end
        end
        else if (bypass)
        begin
            // samples straight through, strobe runs free
            if (tick)
            begin
                next_st.out_data = adc_sample; // RULE_13 RULE_20
                next_st.strobe = edge_eff; // RULE_16 RULE_17
            end
            else if (st.div_cnt == half_pt)
            begin
                next_st.strobe = ~edge_eff; // RULE_17
            end
        end
        else if (st.rd_pend)
        begin
            next_st.out_data = mem_rdata; // RULE_14 RULE_16
            next_st.strobe = edge_eff; // RULE_17
        end
        else if ((rclk_rise && !read_now) || !st.ren_s)
        begin
            // nothing valid, or no reader: rest at the idle level
            next_st.out_data = edge_eff ? 8'h00 : 8'hFF; // RULE_11 RULE_15
            next_st.strobe = ~edge_eff;
        end
        else if (rclk_fall)
        begin
            next_st.strobe = ~edge_eff; // RULE_17
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= RESET_STATE; // RULE_21
        end
        else
        begin
            st <= next_st;
        end
    end

    // capture memory
    buf_mem u_mem (
        .pclk(pclk),
        .wr_en(mem_we),
        .wr_addr(st.wr_ptr),
        .wr_data(adc_sample),
        .rd_addr(st.rd_ptr),
        .rd_data(mem_rdata)
    );

    // outputs
    assign prdata = st.prdata;
    assign out_data = st.out_data;
    assign data_strobe_out = st.strobe;
    assign out_data_oe_n = ~(out_enable | test_mode); // RULE_18
    assign data_strobe_oe_n = ~(out_enable | test_mode); // RULE_18
    assign sample_strobe_out = st.smp_strobe;
    assign empty_flag = st.empty;
    assign full_flag = st.full;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_last_write;
        !bypass && mem_we && st.level != size_bytes && 11'(st.level + 11'h001) == size_bytes;
    endsequence

    sequence s_restart;
        !bypass && wen_rise;
    endsequence

    a_tick_spacing: assert property ( // RULE_02
        tick && div_len > 5'h01 |=> !tick
    ) else $error("sample tick repeated too soon");

    a_bypass_flags: assert property ( // RULE_13
        bypass |=> !empty_flag && !full_flag
    ) else $error("flags not low in bypass");

    a_wen_restart: assert property ( // RULE_07
        s_restart |=> st.level == 11'h000 && empty_flag && !full_flag && st.wr_ptr == 10'h000
    ) else $error("write enable did not restart capture");

    a_wen_priority: assert property ( // RULE_08
        st.wen_s |=> !st.rd_pend
    ) else $error("read taken while writing");

    a_asw_halt: assert property ( // RULE_09
        !bypass && st.wen_s && !wen_rise && auto_stop_write && st.level == size_bytes
        |=> $stable(st.wr_ptr)
    ) else $error("write continued past full with auto-stop");

    a_read_gate: assert property ( // RULE_05
        st.rd_pend |-> $past(st.filled)
    ) else $error("read before buffer filled");

    a_full_rise: assert property ( // RULE_12
        s_last_write |=> full_flag ##1 full_flag || st.ren_s || st.wen_s
    ) else $error("full flag missing at size");

    a_idle_level: assert property ( // RULE_15
        !bypass && !test_mode && rclk_rise && !read_now && !st.rd_pend
        |=> out_data == (edge_eff ? 8'h00 : 8'hFF) && data_strobe_out == ~edge_eff
    ) else $error("outputs not at idle level");

    a_bypass_data: assert property ( // RULE_16
        bypass && !test_mode && tick |=> out_data == $past(adc_sample)
        && data_strobe_out == edge_eff
    ) else $error("bypass data not with strobe edge");

    a_out_float: assert property ( // RULE_18
        !out_enable && !test_mode |-> out_data_oe_n && data_strobe_oe_n
    ) else $error("outputs driven while disabled");

endmodule : capbuf_port

// File: capbuf_regs.svh
/*
 * constants of the capture buffer and output port: register offsets,
 * field positions, reset values and sample clock timing counts.
 * assumes a 12-bit apb byte address and 32-bit data.
 */
`ifndef CAPBUF_REGS_SVH
`define CAPBUF_REGS_SVH

// register byte offsets
`define CFG_OFFSET 12'h000
`define STATUS_OFFSET 12'h004

// config field positions
`define CFG_MULT_LO 0
`define CFG_MULT_HI 1
`define CFG_SIZE_LO 2
`define CFG_SIZE_HI 3
`define CFG_ASW 4
`define CFG_EDGE 5
`define CFG_OE 6
`define CFG_TEST 7

// config reset: 1024-byte buffer, pll bypassed, rising edge, outputs enabled
`define CFG_RST 8'h6C

// status field positions
`define STAT_EMPTY 0
`define STAT_FULL 1
`define STAT_PHASE_LSB 2
`define STAT_LEVEL_LSB 4
`define STAT_WPTR_LSB 16

// input clock period in pclk cycles; sample period is this over the multiplier
`define SAMPLE_DIV_BASE 5'h10

// buffer sizes in bytes
`define SIZE_256 11'h100
`define SIZE_512 11'h200
`define SIZE_1024 11'h400

`endif

// File: capbuf_pkg.sv
/*
 * types of the capture buffer and output port.
 * assumes capbuf_regs.svh for all numeric constants.
 */
package capbuf_pkg;

    // buffer activity shown in status
    typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} buf_phase_t;

    // whole state of the main module
    typedef struct packed {
        logic [7:0] cfg;
        logic wen_m;
        logic wen_s;
        logic wen_d;
        logic ren_m;
        logic ren_s;
        logic rclk_m;
        logic rclk_s;
        logic rclk_d;
        logic [4:0] div_cnt;
        logic [9:0] wr_ptr;
        logic [9:0] rd_ptr;
        logic [10:0] level;
        logic filled;
        logic empty;
        logic full;
        logic rd_pend;
        logic strobe;
        logic test_hi;
        logic smp_strobe;
        buf_phase_t phase;
        logic [7:0] out_data;
        logic [31:0] prdata;
    } state_t;

endpackage : capbuf_pkg

// File: buf_mem.sv
/*
 * 1024 x 8 capture memory, one write port and one read port.
 * assumes a single clock; read data come from a register one cycle later.
 */
`timescale 1ns/1ps
module buf_mem (
    input wire logic pclk,
    input wire logic wr_en,
    input wire logic [9:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [9:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:1023];

    // write on enable, read data registered every cycle
    always_ff @(posedge pclk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule : buf_mem

// File: rd_partner.sv
/*
 * model of the receiving device on the read side: read clock and read enable,
 * captures one byte per read clock period into a queue.
 * assumes pclk at 40 MHz; the read clock runs at 8 pclk a period, only in frames.
 */
`timescale 1ns/1ps
module rd_partner (
    input wire logic pclk,
    input wire logic go,
    input wire logic [10:0] n_rd,
    input wire logic [7:0] out_data,
    output logic rclk_in,
    output logic ren_in,
    output logic busy
);
    logic [7:0] got [$];
    int k;

    // one frame per go: n_rd captured bytes plus one closing rise
    initial
    begin
        rclk_in = 1'b0;
        ren_in = 1'b0;
        busy = 1'b0;
        forever
        begin
            @(posedge pclk);
            if (go === 1'b1)
            begin
                busy <= 1'b1;
                ren_in <= 1'b1;
                repeat (4) @(posedge pclk);
                for (k = 0; k <= n_rd; k++)
                begin
                    rclk_in <= 1'b1;
                    repeat (4) @(posedge pclk);
                    rclk_in <= 1'b0;
                    repeat (3) @(posedge pclk);
                    if (k < n_rd)
                        got.push_back(out_data);
                    @(posedge pclk);
                end
                ren_in <= 1'b0; // rclk stands low between frames
                busy <= 1'b0;
            end
        end
    end
endmodule : rd_partner

// File: tb.sv
/*
 * self-checking bench of capbuf_port: apb tasks, fill, read and mode scenarios.
 * assumes rd_partner on the read side; adc samples come from a random table.
 */
`timescale 1ns/1ps
`include "capbuf_regs.svh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, sprev;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] adc_sample, out_data;
    logic [7:0] pat [0:2047];
    logic wen_in, ren_in, rclk_in, out_data_oe_n, data_strobe_out, data_strobe_oe_n;
    logic sample_strobe_out, empty_flag, full_flag, pll_enable, go, busy;
    logic [10:0] n_rd;
    int bad_count, n_checks, tcnt, stog, w, i, j, s0, off;
    integer seed;

    capbuf_port DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .adc_sample(adc_sample),
        .wen_in(wen_in), .ren_in(ren_in), .rclk_in(rclk_in), .out_data(out_data),
        .out_data_oe_n(out_data_oe_n), .data_strobe_out(data_strobe_out),
        .data_strobe_oe_n(data_strobe_oe_n), .sample_strobe_out(sample_strobe_out),
        .empty_flag(empty_flag), .full_flag(full_flag), .pll_enable(pll_enable)
    );

    rd_partner P (
        .pclk(pclk), .go(go), .n_rd(n_rd), .out_data(out_data),
        .rclk_in(rclk_in), .ren_in(ren_in), .busy(busy)
    );

    // clock
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // strobe toggle count; sample index runs with ticks while writing
    always @(posedge pclk)
    begin
        sprev <= data_strobe_out;
        if (sprev !== data_strobe_out)
            stog <= stog + 1;
        tcnt <= (wen_in !== 1'b1) ? 0 : tcnt + (sample_strobe_out === 1'b1);
        adc_sample <= pat[tcnt];
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one bounded clock step
    task step(inout int c);
        @(posedge pclk);
        c++;
        if (c > 30000)
        begin
            bad_count++;
            report_and_stop();
        end
    endtask : step

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int c;
        c = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        step(c);
        while (pready !== 1'b1)
            step(c);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task cfg(input logic [7:0] v);
        apb(1'b1, `CFG_OFFSET, {24'h0, v});
        // let the new setting settle for two clocks
        repeat (2) @(posedge pclk);
    endtask : cfg

    // write enable until full, then extra ticks
    task fill(input int extra);
        int c, t;
        c = 0;
        t = 0;
        wen_in <= 1'b1;
        repeat (6) step(c);
        while (full_flag !== 1'b1)
            step(c);
        while (t < extra)
        begin
            step(c);
            t += (sample_strobe_out === 1'b1);
        end
        wen_in <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : fill

    task rd(input int n);
        int c;
        c = 0;
        P.got.delete();
        n_rd <= n;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        step(c);
        while (busy === 1'b1)
            step(c);
        repeat (8) @(posedge pclk);
    endtask : rd

    // index of the first captured byte in the table, searched in lo..hi
    task find(input int lo, input int hi);
        off = 3000;
        for (j = hi; j >= lo; j--)
            if (pat[j] === P.got[0])
                off = j;
        chk("start", 1, off < 3000);
    endtask : find

    initial
    begin
        seed = 32'hb77fbc62;
        for (i = 0; i < 2048; i++)
            pat[i] = $random(seed);
        {presetn, psel, penable, pwrite, wen_in, go, sprev} = 7'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_rd = 11'h000;
        adc_sample = 8'h00;
        {stog, tcnt} = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk("empty", 1, empty_flag);
        chk("full", 0, full_flag);
        chk("idle", 0, {out_data, data_strobe_out});
        apb(1'b0, `CFG_OFFSET, 32'h0);
        chk("cfg", 32'h6C, q);
        apb(1'b0, `STATUS_OFFSET, 32'h0);
        chk("status", 1, q[1:0]);
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", 1, err);
        chk("unmapped", 0, q);
        // multiplier select and sample tick spacing
        for (i = 0; i < 4; i++)
        begin
            cfg(8'h6C | i[7:0]);
            chk("pll", i != 0, pll_enable);
            w = 0;
            while (sample_strobe_out !== 1'b1)
                step(w);
            w = 0;
            step(w);
            while (sample_strobe_out !== 1'b1)
                step(w);
            chk("period", 16 >> i, w);
        end
        // 256 bytes, auto-stop, full read
        cfg(8'h77);
        fill(100);
        chk("full", 1, full_flag);
        chk("empty", 0, empty_flag);
        rd(256);
        chk("count", 256, P.got.size());
        find(0, 3);
        for (i = 0; i < 256; i++)
            chk("fifo", pat[off + i], P.got[i]);
        chk("empty", 1, empty_flag);
        chk("full", 0, full_flag);
        chk("rest", 0, {out_data, data_strobe_out});
        // refill, partial read, restart and refused reads
        fill(0);
        rd(10);
        find(0, 3);
        chk("full", 0, full_flag);
        chk("partial", 0, empty_flag);
        wen_in <= 1'b1;
        s0 = stog;
        rd(4);
        chk("wen wins", s0, stog);
        chk("empty", 0, empty_flag);
        wen_in <= 1'b0;
        s0 = stog;
        rd(4);
        chk("not filled", s0, stog);
        // 512 bytes without auto-stop: older data overwritten
        cfg(8'h6B);
        fill(40);
        rd(8);
        find(34, 46);
        for (i = 1; i < 8; i++)
            chk("wrap", pat[off + i], P.got[i]);
        // edge select low, output enable, test mode
        cfg(8'h57);
        repeat (20) @(posedge pclk);
        chk("idle high", 9'h1FF, {out_data, data_strobe_out});
        cfg(8'h17);
        chk("float", 2'b11, {out_data_oe_n, data_strobe_oe_n});
        cfg(8'h97);
        chk("test drive", 2'b00, {out_data_oe_n, data_strobe_oe_n});
        rd(2);
        chk("pattern", 8'hFF, P.got[0] ^ P.got[1]);
        // bypass: controls ignored, flags low, strobe free running
        cfg(8'h63);
        wen_in <= 1'b1;
        s0 = stog;
        repeat (40) @(posedge pclk);
        chk("bypass flags", 0, {empty_flag, full_flag});
        chk("bypass strobe", 1, stog - s0 > 30);
        wen_in <= 1'b0;
        report_and_stop();
    end
endmodule : tb
